// ==== logic/pxy_pkg.sv ====
// shared constants and types for the i2c proxy master hub
package pxy_pkg;
  localparam logic [7:0] REG_GEN_CFG     = 8'h02;
  localparam logic [7:0] REG_SCL_HIGH    = 8'h0A;
  localparam logic [7:0] REG_SCL_LOW     = 8'h0B;
  localparam logic [7:0] REG_PROXY_STS   = 8'h0C;
  localparam logic [7:0] REG_PORT_SEL    = 8'h4C;
  localparam int         GEN_MASTER_EN   = 5;
  localparam int         PSEL_RD_LSB     = 4;
  localparam logic [7:0] GEN_CFG_RESET   = 8'h00;
  localparam logic [7:0] PORT_SEL_RESET  = 8'h01;
  localparam logic [7:0] SCL_COUNT_RESET = 8'h7A;
  localparam int         CLOCK_NS        = 40;
  localparam int         OSC_PERIOD_NS   = 40;
  localparam int         EXTRA_PERIODS   = 4;
  localparam int         MIN_PHASE_NS    = 5000;
  localparam int         EXTRA_CYCLES    =
    (EXTRA_PERIODS * OSC_PERIOD_NS + CLOCK_NS - 1) / CLOCK_NS;

  typedef enum {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH,
    ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_REL, ST_WAIT_STOP
  } pxy_state_type;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } pxy_req_type;

  typedef struct packed {
    logic       nack;
    logic [7:0] data;
  } pxy_rsp_type;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } pxy_bus_type;
endpackage : pxy_pkg

// ==== logic/pxy_port.sv ====
// one proxy master engine: single-byte read or write with arbitration
`timescale 1ns/1ns
module pxy_port
  import pxy_pkg::*;
(
  // clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_rst_b,
  // configuration
  input  wire logic        i_enable,
  input  wire logic [7:0]  i_high_cnt,
  input  wire logic [7:0]  i_low_cnt,
  // request from the control channel
  input  wire logic        i_req_valid,
  input  wire pxy_req_type i_req,
  output pxy_rsp_type      o_rsp,
  output logic             o_rsp_valid,
  output logic             o_active,
  // bus
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_bus_busy,
  input  wire logic        i_stop_seen,
  output pxy_bus_type      o_drive
);
  pxy_state_type st_q, st_d;
  pxy_req_type   req_q, req_d;
  pxy_bus_type   drv_q, drv_d;
  pxy_rsp_type   rsp_q, rsp_d;
  logic [8:0]    cnt_q, cnt_d, tx_q, tx_d, limit;
  logic [7:0]    rx_q, rx_d;
  logic [3:0]    bit_q, bit_d;
  logic          byte_q, byte_d, nack_q, nack_d, rv_q, rv_d;
  logic          hi_phase, done, mst_bit, lost;

  always_comb begin
    hi_phase = (st_q == ST_START) || (st_q == ST_HIGH) || (st_q == ST_STOP_HIGH)
               || (st_q == ST_STOP_REL);
    // phase lasts programmed count plus the synchronisation allowance
    limit    = 9'(hi_phase ? i_high_cnt : i_low_cnt)
               + 9'(EXTRA_CYCLES - 1);
    done     = cnt_q >= limit;
    mst_bit  = (!byte_q || !req_q.rd) && (bit_q != 4'h8);
    lost     = (st_q == ST_HIGH) && i_scl && mst_bit && tx_q[8] && !i_sda;
    st_d = st_q; req_d = req_q; drv_d = drv_q; cnt_d = cnt_q + 9'h001;
    tx_d = tx_q; rx_d = rx_q; bit_d = bit_q; byte_d = byte_q;
    nack_d = nack_q; rv_d = 1'b0; rsp_d = rsp_q;
    case (st_q)
      ST_IDLE: begin
        drv_d = '0;
        cnt_d = '0;
        // enable gates regeneration; a busy bus defers the start
        if (i_enable && i_req_valid && !i_bus_busy) begin
          req_d  = i_req;
          tx_d   = {i_req.addr, i_req.rd, 1'b1};
          bit_d  = '0;
          byte_d = 1'b0;
          nack_d = 1'b0;
          drv_d.sda_oe = 1'b1;
          st_d   = ST_START;
        end
      end
      // another master already pulled scl low: join its low phase at once
      ST_START: if (done || !i_scl) begin
        drv_d.scl_oe = 1'b1;
        cnt_d = '0;
        st_d  = ST_LOW;
      end
      ST_LOW: begin
        drv_d.sda_oe = ~tx_q[8];
        if (done) begin
          drv_d.scl_oe = 1'b0;
          cnt_d = '0;
          st_d  = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (!i_scl && cnt_q == '0) begin
          cnt_d = '0; // slave stretching holds the high count
        end else if (lost) begin
          drv_d = '0;
          st_d  = ST_WAIT_STOP;
        end else if (done || !i_scl) begin
          // scl falling after the high count started is another master's clock
          drv_d.scl_oe = 1'b1;
          cnt_d = '0;
          tx_d  = {tx_q[7:0], 1'b1};
          st_d  = ST_LOW;
          if (bit_q != 4'h8) begin
            rx_d  = {rx_q[6:0], i_sda};
            bit_d = bit_q + 4'h1;
          end else if (!byte_q && i_sda) begin
            nack_d = 1'b1;
            st_d   = ST_STOP_LOW;
          end else if (byte_q) begin
            nack_d = !req_q.rd && i_sda;
            st_d   = ST_STOP_LOW;
          end else begin
            byte_d = 1'b1;
            bit_d  = '0;
            tx_d   = req_q.rd ? 9'h1FF : {req_q.data, 1'b1};
          end
        end
      end
      ST_STOP_LOW: begin
        drv_d.sda_oe = 1'b1;
        if (done) begin
          drv_d.scl_oe = 1'b0;
          cnt_d = '0;
          st_d  = ST_STOP_HIGH;
        end
      end
      ST_STOP_HIGH: begin
        if (!i_scl) begin
          cnt_d = '0;
        end else if (done) begin
          drv_d.sda_oe = 1'b0;
          cnt_d = '0;
          st_d  = ST_STOP_REL;
        end
      end
      ST_STOP_REL: if (done) begin
        // answer only after bus free time so a retried request cannot crowd it
        rv_d  = 1'b1;
        rsp_d = '{nack: nack_q, data: rx_q};
        st_d  = ST_IDLE;
      end
      ST_WAIT_STOP: begin
        drv_d = '0;
        cnt_d = '0;
        if (i_stop_seen) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_q <= ST_IDLE; req_q <= '0; drv_q <= '0; cnt_q <= '0; tx_q <= '0;
      rx_q <= '0; bit_q <= '0; byte_q <= 1'b0; nack_q <= 1'b0; rv_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      st_q <= st_d; req_q <= req_d; drv_q <= drv_d; cnt_q <= cnt_d; tx_q <= tx_d;
      rx_q <= rx_d; bit_q <= bit_d; byte_q <= byte_d; nack_q <= nack_d; rv_q <= rv_d;
      rsp_q <= rsp_d;
    end
  end

  assign o_drive     = drv_q;
  assign o_rsp       = rsp_q;
  assign o_rsp_valid = rv_q;
  assign o_active    = (st_q != ST_IDLE);

  // helper: length of the current driven-low scl run
  logic [9:0] run_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) run_q <= '0;
    else          run_q <= drv_q.scl_oe ? run_q + 10'h001 : '0;
  end

  chk_low_width: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $fell(drv_q.scl_oe) && $past(st_q) == ST_LOW |->
      int'(run_q) >= int'(i_low_cnt) + EXTRA_PERIODS)
    else $error("scl low phase too short");
  chk_disabled_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    st_q == ST_IDLE && !i_enable |=> st_q == ST_IDLE)
    else $error("proxy started while disabled");
  chk_busy_defer: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    st_q == ST_IDLE && i_bus_busy |=> st_q == ST_IDLE)
    else $error("start on busy bus");
  chk_lost_release: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    lost |=> drv_q == '0 && st_q == ST_WAIT_STOP)
    else $error("bus not released after lost arbitration");
  chk_wait_stop: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    st_q == ST_WAIT_STOP && !i_stop_seen |=> st_q == ST_WAIT_STOP && drv_q == '0)
    else $error("retry before stop");
  chk_stretch_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    st_q == ST_HIGH && !i_scl && cnt_q == '0 |=> cnt_q == '0 && !drv_q.scl_oe)
    else $error("high count ran during stretch");
  chk_rsp_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    rv_q |-> $past(st_q) == ST_STOP_REL ##1 !rv_q)
    else $error("bad response pulse");
  cov_lost: cover property (@(posedge i_clock) disable iff (!i_rst_b) lost);
  cov_read: cover property (@(posedge i_clock) disable iff (!i_rst_b) rv_q && req_q.rd);
  cov_nack: cover property (@(posedge i_clock) disable iff (!i_rst_b) rv_q && rsp_q.nack);
endmodule : pxy_port

// ==== logic/pxy_hub.sv ====
// proxy master hub: registers, bus monitor and one engine per receive port
`timescale 1ns/1ns
// Operation
// - Each engine regenerates a remote read or write as a master on the local bus.
// - The proxy enable bit resets to zero and blocks regeneration until set.
// - Standard, fast and fast-plus timing all come from the programmed counts.
// - An engine loses arbitration when it releases SDA high but sees it low.
// - Every receive port has its own independent proxy engine.
// - Contention between engines and other masters resolves by deferring starts on a busy bus, then by bus arbitration.
// - Timing counts run on the reference clock or the 25 MHz oscillator before it.
// - The 8-bit high count sets the width of the released SCL phase.
// - The 8-bit low count sets the width of the driven-low SCL phase.
// - Each phase lasts at least the count plus four 40 ns periods, unless another master pulls SCL low during a high phase.
// - The local slave uses the low count as SDA setup before releasing stretched SCL.
// - Reset counts give at least 5 us per phase at 25 MHz.
module pxy_hub
  import pxy_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // control channel requests, one per receive port
  input  wire logic        i_req_valid [NUM_PORTS],
  input  wire pxy_req_type i_req       [NUM_PORTS],
  output logic             o_rsp_valid [NUM_PORTS],
  output pxy_rsp_type      o_rsp       [NUM_PORTS],
  // local slave sda setup interval for the selected port
  output logic      [7:0]  o_slave_setup_cnt,
  // local i2c bus, open drain
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_scl,
  output logic             o_scl_oe,
  output logic             o_sda,
  output logic             o_sda_oe
);
  logic [7:0]  gen_q, gen_d, psel_q, psel_d, rdata_q, rdata_d, setup_q, setup_d;
  logic [7:0]  hi_q [NUM_PORTS];
  logic [7:0]  hi_d [NUM_PORTS];
  logic [7:0]  lo_q [NUM_PORTS];
  logic [7:0]  lo_d [NUM_PORTS];
  logic [1:0]  rd_port;
  logic        scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic        pscl_q, psda_q, busy_q, busy_d, stop_q, stop_d;
  logic        start_det, stop_det;
  pxy_bus_type drive  [NUM_PORTS];
  logic        active [NUM_PORTS];
  pxy_rsp_type rsp    [NUM_PORTS];
  logic        rsp_v  [NUM_PORTS];

  assign rd_port = psel_q[PSEL_RD_LSB +: 2];

  // register file; counts are per port, written through the select mask
  always_comb begin
    gen_d  = gen_q;
    psel_d = psel_q;
    hi_d   = hi_q;
    lo_d   = lo_q;
    if (i_reg_wr) begin
      case (i_reg_addr)
        REG_GEN_CFG:  gen_d  = i_reg_wdata;
        REG_PORT_SEL: psel_d = i_reg_wdata;
        REG_SCL_HIGH: for (int p = 0; p < NUM_PORTS; p++) begin
          if (psel_q[p]) hi_d[p] = i_reg_wdata;
        end
        REG_SCL_LOW: for (int p = 0; p < NUM_PORTS; p++) begin
          if (psel_q[p]) lo_d[p] = i_reg_wdata;
        end
        default: gen_d = gen_q;
      endcase
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      case (i_reg_addr)
        REG_GEN_CFG:   rdata_d = gen_q;
        REG_PORT_SEL:  rdata_d = psel_q;
        REG_SCL_HIGH:  rdata_d = hi_q[rd_port];
        REG_SCL_LOW:   rdata_d = lo_q[rd_port];
        REG_PROXY_STS: begin
          rdata_d    = 8'h00;
          rdata_d[7] = busy_q;
          for (int p = 0; p < NUM_PORTS; p++) rdata_d[p] = active[p];
        end
        default:       rdata_d = 8'h00;
      endcase
    end
    // the slave side reuses the low count as its data setup time
    setup_d = lo_q[rd_port];
  end

  // bus monitor: start and stop seen by any master, including our own engines
  always_comb begin
    start_det = pscl_q && i_scl && psda_q && !i_sda;
    stop_det  = pscl_q && i_scl && !psda_q && i_sda;
    busy_d    = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_q);
    stop_d    = stop_det;
    // wired-and of all engines: every engine sees the others on the pins
    scl_oe_d  = 1'b0;
    sda_oe_d  = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      scl_oe_d = scl_oe_d | drive[p].scl_oe;
      sda_oe_d = sda_oe_d | drive[p].sda_oe;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      gen_q    <= GEN_CFG_RESET;
      psel_q   <= PORT_SEL_RESET;
      for (int p = 0; p < NUM_PORTS; p++) begin
        hi_q[p] <= SCL_COUNT_RESET;
        lo_q[p] <= SCL_COUNT_RESET;
      end
      rdata_q  <= 8'h00;
      setup_q  <= SCL_COUNT_RESET;
      pscl_q   <= 1'b1;
      psda_q   <= 1'b1;
      busy_q   <= 1'b0;
      stop_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      gen_q    <= gen_d;
      psel_q   <= psel_d;
      hi_q     <= hi_d;
      lo_q     <= lo_d;
      rdata_q  <= rdata_d;
      setup_q  <= setup_d;
      pscl_q   <= i_scl;
      psda_q   <= i_sda;
      busy_q   <= busy_d;
      stop_q   <= stop_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // one engine per receive port; i_clock is the reference or oscillator clock
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    pxy_port u_port (
      .i_clock     (i_clock),
      .i_rst_b     (i_rst_b),
      .i_enable    (gen_q[GEN_MASTER_EN]),
      .i_high_cnt  (hi_q[p]),
      .i_low_cnt   (lo_q[p]),
      .i_req_valid (i_req_valid[p]),
      .i_req       (i_req[p]),
      .o_rsp       (rsp[p]),
      .o_rsp_valid (rsp_v[p]),
      .o_active    (active[p]),
      .i_scl       (i_scl),
      .i_sda       (i_sda),
      .i_bus_busy  (busy_q),
      .i_stop_seen (stop_q),
      .o_drive     (drive[p])
    );
  end

  assign o_reg_rdata       = rdata_q;
  assign o_rsp_valid       = rsp_v;
  assign o_rsp             = rsp;
  assign o_slave_setup_cnt = setup_q;
  assign o_scl             = 1'b0;
  assign o_sda             = 1'b0;
  assign o_scl_oe          = scl_oe_q;
  assign o_sda_oe          = sda_oe_q;

  chk_reset_phase: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> (int'(hi_q[0]) + EXTRA_PERIODS) * OSC_PERIOD_NS >= MIN_PHASE_NS)
    else $error("reset count gives short phase");
  chk_count_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_reg_wr && i_reg_addr == REG_SCL_LOW && psel_q[0] |=> lo_q[0] == $past(i_reg_wdata))
    else $error("low count write lost");
  chk_count_kept: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_reg_wr && i_reg_addr == REG_SCL_HIGH && !psel_q[1] |=> hi_q[1] == $past(hi_q[1]))
    else $error("unselected port count changed");
  chk_stop_frees: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    stop_det |=> !busy_q && stop_q)
    else $error("stop did not free the bus");
  cov_bus_busy: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(busy_q));
  cov_two_ports: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    drive[0].scl_oe && drive[1].scl_oe);
endmodule : pxy_hub

// ==== verification/pxy_slave_model.sv ====
// behavioural local i2c slave with one data register and optional clock stretch
`timescale 1ns/1ns
module pxy_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input  wire logic       i_clock,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [3:0] i_stretch,
  output logic            o_scl_oe,
  output logic            o_sda_oe,
  output logic [7:0]      o_mem
);
  logic       scl_p, sda_p, hit, rd;
  logic [3:0] bit_n, hold;
  logic [1:0] byte_n;
  logic [7:0] sh;
  initial begin
    scl_p = 1'b1; sda_p = 1'b1; hit = 1'b0; rd = 1'b0; bit_n = 4'h0; hold = 4'h0;
    byte_n = 2'h3; sh = 8'h00; o_scl_oe = 1'b0; o_sda_oe = 1'b0; o_mem = 8'hC3;
  end
  always @(posedge i_clock) begin
    scl_p <= i_scl;
    sda_p <= i_sda;
    if (i_scl && scl_p && sda_p && !i_sda) begin
      bit_n <= 4'h0; byte_n <= 2'h0; hit <= 1'b0; o_sda_oe <= 1'b0;
    end else if (i_scl && scl_p && !sda_p && i_sda) begin
      byte_n <= 2'h3; o_sda_oe <= 1'b0;
    end else if (i_scl && !scl_p && byte_n < 2'h2) begin
      if (bit_n < 4'h8) begin
        sh <= {sh[6:0], i_sda};
        bit_n <= bit_n + 4'h1;
      end else begin
        bit_n <= 4'h0;
        byte_n <= byte_n + 2'h1;
        if (byte_n == 2'h0) begin
          hit <= (sh[7:1] == ADDR); rd <= sh[0];
        end else if (hit && !rd) o_mem <= sh;
      end
    end else if (!i_scl && scl_p && byte_n == 2'h2) begin
      // last acknowledge done: free sda so the master can make its stop
      o_sda_oe <= 1'b0;
    end else if (!i_scl && scl_p && byte_n < 2'h2) begin
      // stretching here only lengthens low phases, as a slow remote would
      hold <= i_stretch;
      o_scl_oe <= (i_stretch != 4'h0);
      if (byte_n == 2'h0) o_sda_oe <= (bit_n == 4'h8) && (sh[7:1] == ADDR);
      else if (!rd) o_sda_oe <= (bit_n == 4'h8) && hit;
      else o_sda_oe <= hit && (bit_n < 4'h8) && !o_mem[3'h7 - bit_n[2:0]];
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
      if (hold == 4'h1) o_scl_oe <= 1'b0;
    end
  end
endmodule : pxy_slave_model

// ==== verification/pxy_hub_test.sv ====
// self-checking bench for the proxy master hub
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module pxy_hub_test;
  import pxy_pkg::*;
  localparam int         NP  = 4;
  localparam logic [6:0] SLV = 7'h50;
  logic        i_clock, i_rst_b, reg_wr, reg_rd, scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  logic        tb_sda_oe, scl, sda, meas, prev_scl, run_ok;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, setup_cnt, mem, d;
  logic [3:0]  stretch;
  logic        req_valid [NP];
  pxy_req_type req       [NP];
  logic        rsp_valid [NP];
  pxy_rsp_type rsp       [NP];
  logic [31:0] lfsr_q;
  int          err_total, comparisons, run, min_lo, min_hi, k, quiet;
  // open-drain wires with pull-up
  assign scl = !(scl_oe || s_scl_oe);
  assign sda = !(sda_oe || s_sda_oe || tb_sda_oe);
  pxy_hub #(.NUM_PORTS(NP)) u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_req_valid(req_valid), .i_req(req), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
    .o_slave_setup_cnt(setup_cnt), .i_scl(scl), .i_sda(sda), .o_scl(), .o_scl_oe(scl_oe),
    .o_sda(), .o_sda_oe(sda_oe));
  pxy_slave_model #(.ADDR(SLV)) u_slave (.i_clock(i_clock), .i_scl(scl), .i_sda(sda),
    .i_stretch(stretch), .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe), .o_mem(mem));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // phase widths on the wire; partial phases at the ends are not recorded
  always @(posedge i_clock) begin
    if (meas && scl != prev_scl) begin
      if (run_ok && prev_scl && run < min_hi) min_hi = run;
      if (run_ok && !prev_scl && run < min_lo) min_lo = run;
      run = 1;
      run_ok = 1'b1;
    end else run++;
    if (!meas) run_ok = 1'b0;
    prev_scl = scl;
  end
  function automatic logic [7:0] rnd8();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction : rnd8
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clock); reg_wr = 1'b1; reg_addr = a; reg_wdata = v;
    @(negedge i_clock); reg_wr = 1'b0;
  endtask : reg_write
  task automatic reg_check(input logic [7:0] a, input logic [7:0] ex);
    @(negedge i_clock); reg_rd = 1'b1; reg_addr = a;
    @(negedge i_clock); reg_rd = 1'b0;
    `CHK("reg_rdata", ex, reg_rdata)
  endtask : reg_check
  task automatic xfer(input int p, input logic r, input logic [6:0] a, input logic [7:0] v,
                      input logic ex_nack, input logic [7:0] ex_d);
    int n;
    @(negedge i_clock); req[p] = '{r, a, v}; req_valid[p] = 1'b1;
    for (n = 0; n < 40000 && rsp_valid[p] !== 1'b1; n++) @(negedge i_clock);
    req_valid[p] = 1'b0;
    if (n == 40000) begin `CHK("rsp_valid", 1'b1, rsp_valid[p]) stop_test(); end
    `CHK("rsp_nack", ex_nack, rsp[p].nack)
    if (r && !ex_nack) `CHK("rsp_data", ex_d, rsp[p].data)
  endtask : xfer
  task automatic mode_run(input logic [7:0] hi, input logic [7:0] lo, input logic [3:0] st);
    logic [7:0] v;
    v = rnd8();
    reg_write(REG_PORT_SEL, 8'h01);
    reg_write(REG_SCL_HIGH, hi);
    reg_write(REG_SCL_LOW, lo);
    reg_check(REG_SCL_HIGH, hi);
    reg_check(REG_SCL_LOW, lo);
    `CHK("setup_cnt", lo, setup_cnt)
    stretch = st; min_lo = 9999; min_hi = 9999; meas = 1'b1;
    xfer(0, 1'b0, SLV, v, 1'b0, 8'h00);
    meas = 1'b0;
    `CHK("slave_mem", v, mem)
    `CHK("low_width", 1'b1, min_lo >= lo + 4 && min_lo <= lo + 6)
    `CHK("high_width", 1'b1, min_hi >= hi + 4 && min_hi <= hi + 6)
    xfer(0, 1'b1, SLV, 8'h00, 1'b0, v);
    xfer(0, 1'b1, SLV ^ 7'h01, 8'h00, 1'b1, 8'h00);
  endtask : mode_run
  initial begin
    i_rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    tb_sda_oe = 1'b0; stretch = 4'h0; meas = 1'b0; prev_scl = 1'b1; run_ok = 1'b0; run = 0;
    lfsr_q = 32'h4EA6; err_total = 0; comparisons = 0; k = 0;
    for (int p = 0; p < NP; p++) begin req_valid[p] = 1'b0; req[p] = '0; end
    repeat (12) @(negedge i_clock);
    i_rst_b = 1'b1;
    reg_check(REG_GEN_CFG, 8'h00);
    reg_check(REG_PORT_SEL, PORT_SEL_RESET);
    reg_check(REG_SCL_LOW, SCL_COUNT_RESET);
    reg_check(REG_SCL_HIGH, SCL_COUNT_RESET);
    `CHK("std_phase_ns", 1'b1, 40 * (reg_rdata + 4) >= 5000)
    reg_check(8'h33, 8'h00);
    // a pending request must not reach the pins while the enable bit is clear
    req[0] = '{1'b0, SLV, 8'h5A}; req_valid[0] = 1'b1;
    repeat (300) @(negedge i_clock) if (scl_oe !== 1'b0 || sda_oe !== 1'b0) k++;
    reg_check(REG_PROXY_STS, 8'h00);
    req_valid[0] = 1'b0;
    `CHK("blocked", 0, k)
    reg_write(REG_GEN_CFG, 8'h3E);
    reg_check(REG_GEN_CFG, 8'h3E);
    mode_run(8'h7A, 8'h7A, 4'h0);
    mode_run(8'h13, 8'h25, 4'hF);
    mode_run(8'h06, 8'h0C, 4'h0);
    // per-port counts: write port 1 only, read it back through the read field
    reg_write(REG_PORT_SEL, 8'h02);
    reg_write(REG_SCL_LOW, 8'h25);
    reg_write(REG_PORT_SEL, 8'h11);
    reg_check(REG_SCL_LOW, 8'h25);
    `CHK("setup_cnt", 8'h25, setup_cnt)
    reg_write(REG_PORT_SEL, 8'h01);
    reg_check(REG_SCL_LOW, 8'h0C);
    d = rnd8();
    fork
      xfer(0, 1'b0, SLV, d, 1'b0, 8'h00);
      xfer(1, 1'b0, SLV, ~d, 1'b0, 8'h00);
    join
    fork
      xfer(2, 1'b1, SLV, 8'h00, 1'b0, mem);
      xfer(3, 1'b1, SLV, 8'h00, 1'b0, mem);
    join
    // another master wins the first address bit; the engine backs off until a stop
    d = rnd8();
    fork
      xfer(0, 1'b0, SLV, d, 1'b0, 8'h00);
      begin
        for (k = 0; k < 3000 && scl_oe !== 1'b1; k++) @(negedge i_clock);
        tb_sda_oe = 1'b1;
        quiet = 0;
        for (k = 0; k < 3000 && quiet < 60; k++) begin
          @(negedge i_clock);
          quiet = (scl_oe === 1'b0 && sda_oe === 1'b0) ? quiet + 1 : 0;
        end
        `CHK("lost_release", 1'b1, quiet >= 60)
        tb_sda_oe = 1'b0;
      end
    join
    `CHK("retry_mem", d, mem)
    for (int i = 0; i < 8; i++) begin
      d = rnd8();
      xfer(0, 1'b0, SLV, d, 1'b0, 8'h00);
      xfer(0, 1'b1, SLV, 8'h00, 1'b0, d);
    end
    stop_test();
  end
endmodule : pxy_hub_test
